// ### dpt_pkg.sv
// Package with register map, field layout and timing constants of the page and turnaround control block.
package dpt_pkg;
    // Register byte offsets.
    localparam logic [11:0] ADDR_TIMING     = 12'h08C;
    localparam logic [11:0] ADDR_CFG_LOW    = 12'h090;
    localparam logic [11:0] ADDR_STATUS     = 12'h0A0;
    localparam logic [11:0] ADDR_GANG       = 12'h110;
    localparam logic [11:0] ADDR_WR_LIMIT   = 12'h11C;

    // Reset values.
    localparam logic [31:0] RST_TIMING      = 32'h0000_0000;
    localparam logic [31:0] RST_CFG_LOW     = 32'h0000_0000;
    localparam logic [31:0] RST_GANG        = 32'h0000_0000;
    localparam logic [31:0] RST_WR_LIMIT    = 32'h0000_0010;

    // Writable bit masks.
    localparam logic [31:0] MASK_TIMING     = 32'h0000_00FF;
    localparam logic [31:0] MASK_CFG_LOW    = 32'h00F0_0600;
    localparam logic [31:0] MASK_GANG       = 32'h0000_0001;
    localparam logic [31:0] MASK_WR_LIMIT   = 32'h0000_001F;

    // Field positions in the timing register.
    localparam int TURN_LSB   = 4;
    localparam int HOLD_LSB   = 0;
    // Field positions in the configuration low register.
    localparam int FAP_BIT    = 23;
    localparam int IDLE_LSB   = 21;
    localparam int DYN_BIT    = 20;
    localparam int SRF_BIT    = 10;
    localparam int B32_BIT    = 9;
    // Field positions in the gang and status registers.
    localparam int GANG_BIT   = 0;
    localparam int ST_OPEN_LSB  = 0;
    localparam int ST_CLOSE_LSB = 8;
    localparam int ST_WR_BIT    = 16;

    // Timing counts in memory clock cycles.
    localparam logic [3:0] TURN_CODE_MIN  = 4'h1;
    localparam logic [3:0] TURN_CODE_MAX  = 4'h7;
    localparam logic [3:0] TURN_OFFSET    = 4'h2;
    localparam logic [3:0] HOLD_CODE_MIN  = 4'h1;
    localparam logic [7:0] IDLE_CLKS_0    = 8'h10;
    localparam logic [7:0] IDLE_CLKS_1    = 8'h20;
    localparam logic [7:0] IDLE_CLKS_2    = 8'h40;
    localparam logic [7:0] IDLE_CLKS_3    = 8'h60;
    localparam logic [7:0] STATIC_CLOSE_CLKS = 8'h80;

    // Burst shapes.
    localparam logic [3:0] BEATS_LONG     = 4'h8;
    localparam logic [3:0] BEATS_SHORT    = 4'h4;
    localparam logic [6:0] BYTES_LONG     = 7'h40;
    localparam logic [6:0] BYTES_SHORT    = 7'h20;
endpackage

// ### dpt_idle_counter.sv
// One bank's open-page idle counter with close request.
`timescale 1ns/1ps
module dpt_idle_counter (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       ce,
    // Bank events
    input  wire logic       activate,
    input  wire logic       access,
    input  wire logic       precharge,
    input  wire logic [7:0] limit,
    // Bank state
    output logic            page_open,
    output logic            page_hit,
    output logic            close_req
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       open_next;
    logic       hit_next;

    // A precharge wins over an activate in the same cycle because the page is gone afterwards.
    assign open_next = precharge ? 1'b0 : (activate ? 1'b1 : page_open);
    assign hit_next  = activate ? 1'b0 : ((access && page_open) ? 1'b1 : page_hit);
    assign cnt_next  = (activate || access) ? 8'h00 :
                       ((page_open && cnt_reg < limit) ? cnt_reg + 8'h01 : cnt_reg);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_reg   <= 8'h00;
            page_open <= 1'b0;
            page_hit  <= 1'b0;
            close_req <= 1'b0;
        end else if (ce) begin
            cnt_reg   <= cnt_next;
            page_open <= open_next;
            page_hit  <= hit_next;
            close_req <= open_next && !activate && (cnt_next >= limit);
        end
    end
endmodule // dpt_idle_counter

// ### dpt_page_turn_ctrl.sv
// Top module: register slave, read-to-write spacing, write release, page close and burst shape control.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module dpt_page_turn_ctrl #(
    parameter int NUM_BANKS = 8,
    parameter int WQ_W      = 5
) (
    // Clock, reset and enable
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Scheduler command events
    input  wire logic                 rd_cas_done,
    input  wire logic                 wr_cas,
    input  wire logic [WQ_W-1:0]      wr_queue_count,
    output logic                      wr_allow,
    output logic                      cmd_auto_precharge,
    // Bank events
    input  wire logic [NUM_BANKS-1:0] bank_activate,
    input  wire logic [NUM_BANKS-1:0] bank_access,
    input  wire logic [NUM_BANKS-1:0] bank_precharge,
    output logic [NUM_BANKS-1:0]      page_close_req,
    // Burst shape and self refresh
    output logic [3:0]                burst_beats,
    output logic [6:0]                access_bytes,
    output logic                      self_refresh_fast,
    output logic                      emrs2_srf_bit
);
    logic [31:0] timing_reg;
    logic [31:0] cfg_low_reg;
    logic [31:0] gang_reg;
    logic [31:0] wr_limit_reg;
    logic [3:0]  turn_cnt_reg;
    logic [3:0]  turn_cnt_next;
    logic [3:0]  hold_cnt_reg;
    logic [3:0]  hold_cnt_next;

    // Byte-lane merge of a write into a register, keeping read-only bits.
    function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~lanes) | (wd & lanes);
    endfunction

    // Down count that stops at zero.
    function automatic logic [3:0] count_down(input logic [3:0] c);
        return (c == 4'h0) ? 4'h0 : c - 4'h1;
    endfunction

    // Reserved turnaround codes are clamped into the legal range so the bus never contends.
    function automatic logic [3:0] turn_clocks(input logic [3:0] code);
        logic [3:0] c;
        c = (code < dpt_pkg::TURN_CODE_MIN) ? dpt_pkg::TURN_CODE_MIN :
            ((code > dpt_pkg::TURN_CODE_MAX) ? dpt_pkg::TURN_CODE_MAX : code);
        return c + dpt_pkg::TURN_OFFSET;
    endfunction

    function automatic logic [7:0] idle_clocks(input logic [1:0] code);
        case (code)
            2'h0:    return dpt_pkg::IDLE_CLKS_0;
            2'h1:    return dpt_pkg::IDLE_CLKS_1;
            2'h2:    return dpt_pkg::IDLE_CLKS_2;
            default: return dpt_pkg::IDLE_CLKS_3;
        endcase
    endfunction

    // Register fields.
    wire [3:0] turn_code  = timing_reg[dpt_pkg::TURN_LSB +: 4];
    wire [3:0] hold_code  = timing_reg[dpt_pkg::HOLD_LSB +: 4];
    wire       force_auto_precharge  = cfg_low_reg[dpt_pkg::FAP_BIT];
    wire [1:0] idle_cycle_init       = cfg_low_reg[dpt_pkg::IDLE_LSB +: 2];
    wire       dynamic_page_close_en = cfg_low_reg[dpt_pkg::DYN_BIT];
    wire       fast_self_refresh_en  = cfg_low_reg[dpt_pkg::SRF_BIT];
    wire       burst_32byte_sel      = cfg_low_reg[dpt_pkg::B32_BIT];
    wire       channel_gang_en       = gang_reg[dpt_pkg::GANG_BIT];
    wire [WQ_W-1:0] write_queue_limit = wr_limit_reg[WQ_W-1:0];

    // APB decode.
    wire setup_phase = psel && !penable;
    wire wr_access   = psel && penable && pready && pwrite;
    wire hit_timing  = (paddr == dpt_pkg::ADDR_TIMING);
    wire hit_cfg     = (paddr == dpt_pkg::ADDR_CFG_LOW);
    wire hit_status  = (paddr == dpt_pkg::ADDR_STATUS);
    wire hit_gang    = (paddr == dpt_pkg::ADDR_GANG);
    wire hit_limit   = (paddr == dpt_pkg::ADDR_WR_LIMIT);
    wire hit_any     = hit_timing || hit_cfg || hit_status || hit_gang || hit_limit;

    // Status register image.
    logic [NUM_BANKS-1:0] bank_open;
    logic [NUM_BANKS-1:0] bank_hit;
    wire [31:0] status_word = (32'(bank_open) << dpt_pkg::ST_OPEN_LSB) |
                              (32'(page_close_req) << dpt_pkg::ST_CLOSE_LSB) |
                              (32'(wr_allow) << dpt_pkg::ST_WR_BIT);

    wire [31:0] read_word = hit_timing ? timing_reg :
                            hit_cfg    ? cfg_low_reg :
                            hit_status ? status_word :
                            hit_gang   ? gang_reg :
                            hit_limit  ? wr_limit_reg : 32'h0000_0000;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            prdata  <= (setup_phase && !pwrite) ? read_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timing_reg   <= dpt_pkg::RST_TIMING;
            cfg_low_reg  <= dpt_pkg::RST_CFG_LOW;
            gang_reg     <= dpt_pkg::RST_GANG;
            wr_limit_reg <= dpt_pkg::RST_WR_LIMIT;
        end else if (ce && wr_access) begin
            if (hit_timing) begin
                timing_reg <= merge_write(timing_reg, pwdata, pstrb, dpt_pkg::MASK_TIMING);
            end
            if (hit_cfg) begin
                cfg_low_reg <= merge_write(cfg_low_reg, pwdata, pstrb, dpt_pkg::MASK_CFG_LOW);
            end
            if (hit_gang) begin
                gang_reg <= merge_write(gang_reg, pwdata, pstrb, dpt_pkg::MASK_GANG);
            end
            if (hit_limit) begin
                wr_limit_reg <= merge_write(wr_limit_reg, pwdata, pstrb, dpt_pkg::MASK_WR_LIMIT);
            end
        end
    end

    // Both counters hold the cycles still to wait; a read reloads them from the registers as they stand now.
    wire [3:0] hold_clocks = (hold_code < dpt_pkg::HOLD_CODE_MIN) ? dpt_pkg::HOLD_CODE_MIN : hold_code;
    assign turn_cnt_next = rd_cas_done ? turn_clocks(turn_code) - 4'h1 : count_down(turn_cnt_reg);
    assign hold_cnt_next = rd_cas_done ? hold_clocks - 4'h1 : count_down(hold_cnt_reg);

    // A write may go once the bus has turned round and either reads have stopped long enough or
    // enough writes have piled up; the turnaround is never waived, since that would fight on the pins.
    wire turn_ok    = (turn_cnt_next == 4'h0) && !rd_cas_done;
    wire holdoff_ok = (hold_cnt_next == 4'h0) && !rd_cas_done;
    wire limit_ok   = (wr_queue_count >= write_queue_limit) && (wr_queue_count != '0);
    wire allow_next = turn_ok && (holdoff_ok || limit_ok);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            turn_cnt_reg <= 4'h0;
            hold_cnt_reg <= 4'h0;
            wr_allow     <= 1'b0;
        end else if (ce) begin
            turn_cnt_reg <= turn_cnt_next;
            hold_cnt_reg <= hold_cnt_next;
            wr_allow     <= allow_next && !wr_cas;
        end
    end

    // Per-bank close limit: with dynamic close on, a page that has been hit since opening earns twice the idle time; otherwise a fixed 128 cycles.
    wire [7:0] idle_limit = idle_clocks(idle_cycle_init);
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            wire [7:0] dyn_limit  = bank_hit[b] ? {idle_limit[6:0], 1'b0}
                                                : idle_limit;
            wire [7:0] bank_limit = dynamic_page_close_en ? dyn_limit
                                                          : dpt_pkg::STATIC_CLOSE_CLKS;
            dpt_idle_counter u_idle (
                .clock     (clock),
                .resetn    (resetn),
                .ce        (ce),
                .activate  (bank_activate[b]),
                .access    (bank_access[b]),
                .precharge (bank_precharge[b]),
                .limit     (bank_limit),
                .page_open (bank_open[b]),
                .page_hit  (bank_hit[b]),
                .close_req (page_close_req[b])
            );
        end
    endgenerate

    // Burst shape and refresh controls follow the configuration one cycle later.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmd_auto_precharge <= 1'b0;
            burst_beats        <= dpt_pkg::BEATS_LONG;
            access_bytes       <= dpt_pkg::BYTES_LONG;
            self_refresh_fast  <= 1'b0;
            emrs2_srf_bit      <= 1'b0;
        end else if (ce) begin
            cmd_auto_precharge <= force_auto_precharge;
            burst_beats        <= (burst_32byte_sel || channel_gang_en) ? dpt_pkg::BEATS_SHORT
                                                                        : dpt_pkg::BEATS_LONG;
            access_bytes       <= burst_32byte_sel ? dpt_pkg::BYTES_SHORT : dpt_pkg::BYTES_LONG;
            self_refresh_fast  <= fast_self_refresh_en;
            emrs2_srf_bit      <= fast_self_refresh_en;
        end
    end
endmodule // dpt_page_turn_ctrl

// ### dpt_page_turn_ctrl_properties.sv
// Port checker for the page and turnaround control block.
`timescale 1ns/1ps
module dpt_page_turn_ctrl_properties #(
    parameter int NUM_BANKS = 8
) (
    // Clock and APB
    input wire logic                 clock,
    input wire logic                 resetn,
    input wire logic                 ce,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Commands and banks
    input wire logic                 rd_cas_done,
    input wire logic                 wr_allow,
    input wire logic                 cmd_auto_precharge,
    input wire logic [NUM_BANKS-1:0] bank_activate,
    input wire logic [NUM_BANKS-1:0] bank_precharge,
    input wire logic [NUM_BANKS-1:0] page_close_req,
    // Burst and self refresh
    input wire logic [3:0]           burst_beats,
    input wire logic [6:0]           access_bytes,
    input wire logic                 self_refresh_fast,
    input wire logic                 emrs2_srf_bit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic map_hit;
    logic cfg_wr;
    assign map_hit = paddr inside {dpt_pkg::ADDR_TIMING, dpt_pkg::ADDR_CFG_LOW, dpt_pkg::ADDR_STATUS,
                                   dpt_pkg::ADDR_GANG, dpt_pkg::ADDR_WR_LIMIT};
    assign cfg_wr = psel && penable && pready && pwrite && paddr == dpt_pkg::ADDR_CFG_LOW;
    a_apb_zero_wait: assert property (psel && !penable && ce |=> pready) else $error("no pready");
    a_apb_unmapped: assert property (pready && !map_hit |-> pslverr) else $error("no pslverr");
    a_apb_idle_data: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not idle");
    a_read_spacing: assert property (rd_cas_done && ce |=> !wr_allow [*2]) else $error("write too soon");
    a_force_pchg: assert property (cfg_wr |-> ##2 cmd_auto_precharge == $past(pwdata[23], 2))
        else $error("auto precharge wrong");
    a_fast_srf: assert property (cfg_wr |-> ##2 self_refresh_fast == $past(pwdata[dpt_pkg::SRF_BIT], 2))
        else $error("self refresh rate wrong");
    a_srf_mirror: assert property (self_refresh_fast == emrs2_srf_bit) else $error("mode bit differs");
    a_long_burst: assert property (burst_beats == 4'h8 |-> access_bytes == 7'h40) else $error("long burst");
    a_short_bytes: assert property (access_bytes == 7'h20 |-> burst_beats == 4'h4) else $error("short burst");
    a_close_quiet: assert property (bank_activate[0] |=> !page_close_req[0] [*8]) else $error("early close");
    a_close_drop: assert property (page_close_req[0] && bank_precharge[0] |=> !page_close_req[0])
        else $error("close request stuck");
    c_cfg_write: cover property (cfg_wr);
    c_turnaround: cover property (rd_cas_done ##[3:15] wr_allow);
    c_page_close: cover property ($rose(page_close_req[0]));
endmodule // dpt_page_turn_ctrl_properties

bind dpt_page_turn_ctrl dpt_page_turn_ctrl_properties #(.NUM_BANKS(NUM_BANKS)) u_props (
    .clock, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rd_cas_done, .wr_allow, .cmd_auto_precharge, .bank_activate, .bank_precharge, .page_close_req,
    .burst_beats, .access_bytes, .self_refresh_fast, .emrs2_srf_bit);

// ### dpt_dram_model.sv
// Behavioural scheduler and DRAM bank side facing the control block.
`timescale 1ns/1ps
module dpt_dram_model #(
    parameter int NUM_BANKS = 8
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // Requests from the bench
    input  wire logic                 rd_req,
    input  wire logic                 wr_pending,
    input  wire logic [NUM_BANKS-1:0] act_req,
    input  wire logic [NUM_BANKS-1:0] acc_req,
    // Control block side
    input  wire logic                 wr_allow,
    input  wire logic [NUM_BANKS-1:0] page_close_req,
    output logic                      rd_cas_done,
    output logic                      wr_cas,
    output logic [NUM_BANKS-1:0]      bank_activate,
    output logic [NUM_BANKS-1:0]      bank_access,
    output logic [NUM_BANKS-1:0]      bank_precharge
);
    // A queued write goes out only in a cycle that the block allows.
    assign wr_cas = wr_pending && wr_allow;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_cas_done <= 1'b0;
            bank_activate <= '0;
            bank_access <= '0;
            bank_precharge <= '0;
        end else begin
            rd_cas_done <= rd_req;
            bank_activate <= act_req;
            bank_access <= acc_req;
            // One precharge pulse per request, so a lingering request is not closed twice.
            bank_precharge <= page_close_req & ~bank_precharge;
        end
    end
endmodule // dpt_dram_model

// ### dpt_page_turn_ctrl_test.sv
// Self-checking bench for the page and turnaround control block.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD %s expected %0h seen %0h", nm, (exp), (got)); end end
module dpt_page_turn_ctrl_test;
    logic        clock, resetn, ce, psel, penable, pwrite, pready, pslverr, rd_cas_done, wr_cas, wr_allow;
    logic        cmd_auto_precharge, self_refresh_fast, emrs2_srf_bit, rd_req, wr_pending;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, d;
    logic [3:0]  pstrb, burst_beats;
    logic [4:0]  wr_queue_count;
    logic [6:0]  access_bytes;
    logic [7:0]  bank_activate, bank_access, bank_precharge, page_close_req, act_req, acc_req;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int          lat_q[$];
    int          pc_q[$];
    int          idle_clks[4] = '{16, 32, 64, 96};
    int          error_cnt, checks_done, le, pe;
    int          lat = -1;
    int          pc = -1;

    dpt_page_turn_ctrl #(.NUM_BANKS(8), .WQ_W(5)) DUT (.clock, .resetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rd_cas_done, .wr_cas, .wr_queue_count,
        .wr_allow, .cmd_auto_precharge, .bank_activate, .bank_access, .bank_precharge, .page_close_req,
        .burst_beats, .access_bytes, .self_refresh_fast, .emrs2_srf_bit);
    dpt_dram_model #(.NUM_BANKS(8)) u_dram (.clock, .resetn, .rd_req, .wr_pending, .act_req, .acc_req,
        .wr_allow, .page_close_req, .rd_cas_done, .wr_cas, .bank_activate, .bank_access, .bank_precharge);

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] ex);
        int n;
        exp_q.push_back(ex);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic turn(input logic [3:0] t, input logic [3:0] h, input logic [4:0] q, input int ex);
        apb(1'b1, dpt_pkg::ADDR_TIMING, {24'h000000, t, h}, 33'h0_0000_0000);
        wr_queue_count <= q;
        lat_q.push_back(ex);
        rd_req <= 1'b1;
        @(posedge clock);
        rd_req <= 1'b0;
        repeat (24) @(posedge clock);
    endtask

    // An access one cycle after activation restarts the idle count; frz cycles with ce low stretch it.
    task automatic pclose(input logic dyn, input logic [1:0] code, input logic acc, input int frz, input int ex);
        apb(1'b1, dpt_pkg::ADDR_CFG_LOW, {8'h00, 1'b0, code, dyn, 20'h00000}, 33'h0_0000_0000);
        pc_q.push_back(ex);
        act_req <= 8'h01;
        @(posedge clock);
        act_req <= 8'h00;
        acc_req <= {7'h00, acc};
        @(posedge clock);
        acc_req <= 8'h00;
        repeat (20) @(posedge clock);
        ce <= (frz == 0);
        repeat (frz) @(posedge clock);
        ce <= 1'b1;
        repeat (200) @(posedge clock);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        if (pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK("apb", e, {pslverr, pwrite ? 32'h0000_0000 : prdata})
        end
        if (rd_cas_done === 1'b1) begin
            lat = 0;
        end else if (lat >= 0) begin
            lat++;
            if (wr_allow === 1'b1) begin
                le = lat_q.pop_front();
                `CHK("turnaround", le, lat)
                lat = -1;
            end
        end
        if (bank_activate[0] === 1'b1) begin
            pc = 0;
        end else if (pc >= 0) begin
            pc++;
            if (page_close_req[0] === 1'b1) begin
                pe = pc_q.pop_front();
                `CHK("page_close", 1'b1, pc >= pe && pc <= pe + 3)
                pc = -1;
            end
        end
    end

    initial begin
        repeat (6000) @(posedge clock);
        error_cnt++;
        summarize();
    end

    initial begin
        seed = 32'h0001_8464;
        {resetn, ce, psel, penable, pwrite, rd_req, wr_pending} = 7'b0100000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        wr_queue_count = 5'h00;
        {act_req, acc_req} = 16'h0000;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        apb(1'b0, dpt_pkg::ADDR_CFG_LOW, 32'h0000_0000, {1'b0, dpt_pkg::RST_CFG_LOW});
        apb(1'b0, dpt_pkg::ADDR_TIMING, 32'h0000_0000, {1'b0, dpt_pkg::RST_TIMING});
        apb(1'b0, dpt_pkg::ADDR_WR_LIMIT, 32'h0000_0000, {1'b0, dpt_pkg::RST_WR_LIMIT});
        // Idle after reset: no page open, no close request, writes allowed.
        apb(1'b0, dpt_pkg::ADDR_STATUS, 32'h0000_0000, {1'b0, 32'h0000_0001 << dpt_pkg::ST_WR_BIT});
        apb(1'b1, 12'h0F0, xs(), 33'h1_0000_0000);
        apb(1'b0, 12'h0F0, 32'h0000_0000, 33'h1_0000_0000);
        for (int i = 0; i < 4; i++) begin
            d = xs();
            wr_pending <= d[0];
            apb(1'b1, dpt_pkg::ADDR_CFG_LOW, d, 33'h0_0000_0000);
            apb(1'b0, dpt_pkg::ADDR_CFG_LOW, 32'h0000_0000, {1'b0, d & dpt_pkg::MASK_CFG_LOW});
            #1;
            `CHK("auto_pchg", d[23], cmd_auto_precharge)
            `CHK("fast_srf", d[dpt_pkg::SRF_BIT], self_refresh_fast)
            `CHK("emrs2_srf", d[dpt_pkg::SRF_BIT], emrs2_srf_bit)
            `CHK("beats", d[9] ? 4'h4 : 4'h8, burst_beats)
            `CHK("bytes", d[9] ? 7'h20 : 7'h40, access_bytes)
            @(posedge clock);
        end
        wr_pending <= 1'b0;
        // Ganged mode with the 32-byte select clear: four-beat bursts, 64-byte accesses.
        apb(1'b1, dpt_pkg::ADDR_GANG, 32'h0000_0001, 33'h0_0000_0000);
        apb(1'b1, dpt_pkg::ADDR_CFG_LOW, 32'h0000_0000, 33'h0_0000_0000);
        #1;
        `CHK("gang_beats", 4'h4, burst_beats)
        `CHK("gang_bytes", 7'h40, access_bytes)
        @(posedge clock);
        apb(1'b1, dpt_pkg::ADDR_GANG, 32'h0000_0000, 33'h0_0000_0000);
        for (int c = 1; c <= 7; c++)
            turn(4'(c), 4'h1, 5'h00, c + 2);
        turn(4'h1, 4'hF, 5'h00, 15);
        turn(4'h3, 4'hA, 5'h00, 10);
        turn(4'h1, 4'hF, 5'h10, 3);
        turn(4'h1, 4'hF, 5'h0F, 15);
        pclose(1'b0, 2'h3, 1'b0, 10, 138);
        for (int k = 0; k < 4; k++)
            pclose(1'b1, 2'(k), 1'b0, 0, idle_clks[k]);
        pclose(1'b1, 2'h1, 1'b1, 0, 2 * idle_clks[1]);
        `CHK("pending", 0, exp_q.size() + lat_q.size() + pc_q.size())
        summarize();
    end
endmodule // dpt_page_turn_ctrl_test
